// [verilog/hsei_pkg.sv]
// package for the head-switch edge interrupt block
package hsei_pkg;
  // byte offsets on the axi4-lite register bus
  localparam logic [7:0] ADDR_ICR = 8'h00;
  localparam logic [7:0] ADDR_TRIG = 8'h04;
  localparam logic [7:0] ADDR_DDC = 8'h08;
  localparam logic [7:0] ADDR_OPT = 8'h0c;
  localparam logic [7:0] ADDR_ANA = 8'h10;
  localparam logic [7:0] ADDR_DTIME = 8'h14;
  localparam logic [7:0] ADDR_MATCH = 8'h18;
  localparam logic [7:0] ADDR_FGDIV = 8'h1c;
  localparam logic [7:0] ADDR_PSW = 8'h20;
  localparam logic [7:0] ADDR_MEMC = 8'h24;
  localparam logic [7:0] ADDR_EVST = 8'h28;
  localparam logic [7:0] ADDR_EVMASK = 8'h2c;
  localparam logic [7:0] ADDR_STAT = 8'h30;
  // field positions
  localparam int ICR_LVL_HI = 7;
  localparam int ICR_LVL_LO = 6;
  localparam int ICR_EN = 1;
  localparam int ICR_FLAG = 0;
  localparam int TRIG_EDGE = 5;
  localparam int TRIG_SRC = 0;
  localparam int DDC_START = 7;
  localparam int DDC_DIGITAL = 6;
  localparam int OPT_SENS = 7;
  localparam int OPT_PGPOL = 6;
  localparam int OPT_SWPOL = 0;
  localparam int ANA_SRC = 0;
  localparam int MATCH_LEVEL = 16;
  localparam int PSW_MIE = 6;
  localparam int PSW_IM_HI = 5;
  localparam int PSW_IM_LO = 4;
  localparam int MEMC_PERMIT = 2;
  // reset values
  localparam logic [7:0] ICR_RST = 8'hc0;
  localparam logic [7:0] ZERO8_RST = 8'h00;
  localparam logic [15:0] ZERO16_RST = 16'h0000;
  localparam logic [1:0] LVL_DISABLED = 2'h3;
  // timing
  localparam int CLK_MHZ = 50;
  localparam real ACK_HOLD_NS = 20.0;
  localparam int ACK_HOLD_CYC = (int'(ACK_HOLD_NS) * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {DL_IDLE, DL_ARMED, DL_RUN} hsei_dly_t;
endpackage : hsei_pkg

// [verilog/hsei_cfg_if.sv]
// configuration bundle from the register file to the switch generator
`timescale 1ns/10ps
interface hsei_cfg_if;
  logic srcSelect;
  logic digitalStart;
  logic digitalDelay;
  logic pulseSrc;
  logic pgPolarity;
  logic swPolarity;
  logic [5:0] startCount;
  logic [15:0] delayTime;
  logic [15:0] matchTime;
  logic storedLevel;
  logic [5:0] fgDivider;
  logic headSwitch;
  modport regs (output srcSelect, digitalStart, digitalDelay, pulseSrc, pgPolarity,
    swPolarity, startCount, delayTime, matchTime, storedLevel, fgDivider,
    input headSwitch);
  modport gen (input srcSelect, digitalStart, digitalDelay, pulseSrc, pgPolarity,
    swPolarity, startCount, delayTime, matchTime, storedLevel, fgDivider,
    output headSwitch);
endinterface : hsei_cfg_if

// [verilog/hsei_switch_gen.sv]
// head-switch signal generator: phase delay or counter match
`timescale 1ns/10ps
module hsei_switch_gen
  import hsei_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // servo inputs
  input wire logic [1:0] combinedLevel,
  input wire logic ampPg,
  input wire logic ampFg,
  input wire logic delayPinHigh,
  input wire logic [15:0] freeRunCount,
  // configuration
  hsei_cfg_if.gen cfg,
  // analog delay pin drive
  output logic delayCharge
);
  logic pgRaw, fgRaw, pg, pgPrev, fgPrev, pgEdge, fgEdge;
  logic [5:0] fgCount_reg;
  logic [15:0] delayCount_reg;
  hsei_dly_t state_reg;
  logic startNow, finishNow, hsw_reg;

  // pulse source choice: three-level input encodes pg as 2, fg as 1
  assign pgRaw = cfg.pulseSrc ? ampPg : (combinedLevel == 2'h2);
  assign fgRaw = cfg.pulseSrc ? ampFg : (combinedLevel == 2'h1);
  assign pg = cfg.pgPolarity ? ~pgRaw : pgRaw;
  assign pgEdge = pg & ~pgPrev;
  assign fgEdge = fgRaw & ~fgPrev;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pgPrev <= 1'b0;
      fgPrev <= 1'b0;
    end else begin
      pgPrev <= pg;
      fgPrev <= fgRaw;
    end
  end

  // fg counter restarts at each pg pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fgCount_reg <= 6'h00;
    end else if (pgEdge) begin
      fgCount_reg <= 6'h00;
    end else if (fgEdge) begin
      if (fgCount_reg == cfg.fgDivider) begin
        fgCount_reg <= 6'h01;
      end else begin
        fgCount_reg <= fgCount_reg + 6'h01;
      end
    end
  end

  // start at count one after pg or after divider match
  // start at programmed count in full digital mode
  always_comb begin
    startNow = 1'b0;
    if (fgEdge && !pgEdge) begin
      if (cfg.digitalStart && cfg.digitalDelay) begin
        startNow = (fgCount_reg + 6'h01) == cfg.startCount;
      end else begin
        startNow = (fgCount_reg == 6'h00) || (fgCount_reg == cfg.fgDivider);
      end
    end
  end

  // analog completes at threshold; digital at count match
  assign finishNow = (state_reg == DL_RUN) &&
    (cfg.digitalDelay ? (delayCount_reg == cfg.delayTime) : delayPinHigh);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= DL_IDLE;
      delayCount_reg <= ZERO16_RST;
    end else begin
      unique case (state_reg)
        DL_IDLE: begin
          if (!cfg.srcSelect) begin
            state_reg <= DL_ARMED;
          end
        end
        DL_ARMED: begin
          delayCount_reg <= ZERO16_RST;
          if (cfg.srcSelect) begin
            state_reg <= DL_IDLE;
          end else if (startNow) begin
            state_reg <= DL_RUN;
          end
        end
        DL_RUN: begin
          delayCount_reg <= delayCount_reg + 16'h0001;
          if (cfg.srcSelect) begin
            state_reg <= DL_IDLE;
          end else if (finishNow) begin
            state_reg <= DL_ARMED;
          end
        end
      endcase
    end
  end

  // charge pin while analog delay runs
  assign delayCharge = (state_reg == DL_RUN) && !cfg.digitalDelay;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hsw_reg <= 1'b0;
    end else if (cfg.srcSelect) begin
      // stored level driven on counter match
      if (freeRunCount == cfg.matchTime) begin
        hsw_reg <= cfg.storedLevel;
      end
    end else if (pgEdge) begin
      // level after pg sets which edge follows
      hsw_reg <= cfg.swPolarity;
    end else if (finishNow) begin
      hsw_reg <= ~hsw_reg;
    end
  end

  assign cfg.headSwitch = hsw_reg;
endmodule : hsei_switch_gen

// [verilog/head_switch_edge_interrupt.sv]
// head-switch both-edge interrupt block with axi4-lite registers
`timescale 1ns/10ps
module head_switch_edge_interrupt
  import hsei_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // servo inputs
  input wire logic [1:0] combinedLevel,
  input wire logic ampPg,
  input wire logic ampFg,
  input wire logic delayPinHigh,
  input wire logic [15:0] freeRunCount,
  // servo outputs
  output logic delayCharge,
  output logic headSwitch,
  output logic captureStrobe,
  // cpu interrupt acceptance
  output logic irqRequest,
  output logic [1:0] irqLevel,
  input wire logic irqAccept,
  // summary interrupt
  output logic irqOut
);
  hsei_cfg_if cfg ();
  logic [7:0] icr_reg, trig_reg, ddc_reg, opt_reg, ana_reg, psw_reg, memc_reg;
  logic [15:0] dtime_reg, match_reg;
  logic [5:0] fgdiv_reg;
  logic storedLevel_reg;
  logic [1:0] evst_reg, evmask_reg;
  logic hswPrev_reg, rise, fall, swEdge;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awHave_reg, wHave_reg, doWrite;
  logic [31:0] rdata_next;
  logic [1:0] levelOk;
  logic admitted;

  hsei_switch_gen u_gen (
    .core_clk(core_clk),
    .srst(srst),
    .combinedLevel(combinedLevel),
    .ampPg(ampPg),
    .ampFg(ampFg),
    .delayPinHigh(delayPinHigh),
    .freeRunCount(freeRunCount),
    .cfg(cfg),
    .delayCharge(delayCharge)
  );

  assign cfg.srcSelect = trig_reg[TRIG_SRC];
  assign cfg.digitalStart = ddc_reg[DDC_START];
  assign cfg.digitalDelay = ddc_reg[DDC_DIGITAL];
  assign cfg.startCount = ddc_reg[5:0];
  assign cfg.pulseSrc = ana_reg[ANA_SRC];
  assign cfg.pgPolarity = opt_reg[OPT_PGPOL];
  assign cfg.swPolarity = opt_reg[OPT_SWPOL];
  assign cfg.delayTime = dtime_reg;
  assign cfg.matchTime = match_reg;
  assign cfg.storedLevel = storedLevel_reg;
  assign cfg.fgDivider = fgdiv_reg;
  assign headSwitch = cfg.headSwitch;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hswPrev_reg <= 1'b0;
    end else begin
      hswPrev_reg <= cfg.headSwitch;
    end
  end
  assign rise = cfg.headSwitch & ~hswPrev_reg;
  assign fall = ~cfg.headSwitch & hswPrev_reg;
  assign swEdge = rise | fall;

  assign captureStrobe = trig_reg[TRIG_EDGE] ? fall : rise;

  // write channel: address and data taken in either order
  assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHave_reg && !s_axi_bvalid;
  assign doWrite = awHave_reg && wHave_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awaddr_reg <= ZERO8_RST;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // unmapped writes are ignored but still answered okay
  assign s_axi_bresp = 2'h0;

  // configuration registers, byte lane 0 except the wide ones
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_reg <= ZERO8_RST;
      ddc_reg <= ZERO8_RST;
      opt_reg <= ZERO8_RST;
      ana_reg <= ZERO8_RST;
      psw_reg <= ZERO8_RST;
      memc_reg <= ZERO8_RST;
      dtime_reg <= ZERO16_RST;
      match_reg <= ZERO16_RST;
      fgdiv_reg <= 6'h00;
      storedLevel_reg <= 1'b0;
      evmask_reg <= 2'h0;
    end else if (doWrite) begin
      if (wstrb_reg[0]) begin
        unique case (awaddr_reg)
          ADDR_TRIG: trig_reg <= wdata_reg[7:0];
          ADDR_DDC: ddc_reg <= wdata_reg[7:0];
          ADDR_OPT: opt_reg <= wdata_reg[7:0];
          ADDR_ANA: ana_reg <= wdata_reg[7:0];
          ADDR_PSW: psw_reg <= wdata_reg[7:0];
          ADDR_MEMC: memc_reg <= wdata_reg[7:0];
          ADDR_FGDIV: fgdiv_reg <= wdata_reg[5:0];
          ADDR_EVMASK: evmask_reg <= wdata_reg[1:0];
          ADDR_DTIME: dtime_reg[7:0] <= wdata_reg[7:0];
          ADDR_MATCH: match_reg[7:0] <= wdata_reg[7:0];
          default: ;
        endcase
      end
      if (wstrb_reg[1]) begin
        if (awaddr_reg == ADDR_DTIME) dtime_reg[15:8] <= wdata_reg[15:8];
        if (awaddr_reg == ADDR_MATCH) match_reg[15:8] <= wdata_reg[15:8];
      end
      if (wstrb_reg[2] && awaddr_reg == ADDR_MATCH) begin
        storedLevel_reg <= wdata_reg[MATCH_LEVEL];
      end
    end
  end

  // level field and enable are plain writes; flag needs the permit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      icr_reg <= ICR_RST;
    end else begin
      if (doWrite && wstrb_reg[0] && awaddr_reg == ADDR_ICR) begin
        icr_reg[7:1] <= wdata_reg[7:1];
        // flag writable only while the permit bit is set
        if (memc_reg[MEMC_PERMIT]) begin
          icr_reg[ICR_FLAG] <= wdata_reg[ICR_FLAG];
        end
      end
      // clear on acceptance, edge event wins over the clear
      if (irqAccept) begin
        icr_reg[ICR_FLAG] <= 1'b0;
      end
      if (swEdge) begin
        icr_reg[ICR_FLAG] <= 1'b1;
      end
    end
  end

  // level 3 disables; mask admits levels below the mask value
  assign irqLevel = icr_reg[ICR_LVL_HI:ICR_LVL_LO];
  assign levelOk = psw_reg[PSW_IM_HI:PSW_IM_LO];
  assign admitted = psw_reg[PSW_MIE] && (irqLevel != LVL_DISABLED) && (irqLevel < levelOk);
  assign irqRequest = icr_reg[ICR_FLAG] && icr_reg[ICR_EN] && admitted;

  // sticky event status: bit0 rise, bit1 fall, write one to clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      evst_reg <= 2'h0;
    end else begin
      if (doWrite && wstrb_reg[0] && awaddr_reg == ADDR_EVST) begin
        evst_reg <= evst_reg & ~wdata_reg[1:0];
      end
      if (rise) evst_reg[0] <= 1'b1;
      if (fall) evst_reg[1] <= 1'b1;
    end
  end
  assign irqOut = |(evst_reg & evmask_reg);

  // read channel: one cycle after address is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (s_axi_araddr)
      ADDR_ICR: rdata_next[7:0] = icr_reg;
      ADDR_TRIG: rdata_next[7:0] = trig_reg;
      ADDR_DDC: rdata_next[7:0] = ddc_reg;
      ADDR_OPT: rdata_next[7:0] = opt_reg;
      ADDR_ANA: rdata_next[7:0] = ana_reg;
      ADDR_DTIME: rdata_next[15:0] = dtime_reg;
      ADDR_MATCH: rdata_next[16:0] = {storedLevel_reg, match_reg};
      ADDR_FGDIV: rdata_next[5:0] = fgdiv_reg;
      ADDR_PSW: rdata_next[7:0] = psw_reg;
      ADDR_MEMC: rdata_next[7:0] = memc_reg;
      ADDR_EVST: rdata_next[1:0] = evst_reg;
      ADDR_EVMASK: rdata_next[1:0] = evmask_reg;
      ADDR_STAT: rdata_next[2:0] = {delayCharge, irqRequest, cfg.headSwitch};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  sequence s_edge;
    cfg.headSwitch != hswPrev_reg;
  endsequence
  property p_edge_flag;
    @(posedge core_clk) disable iff (srst) s_edge |=> icr_reg[ICR_FLAG];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge did not set flag");
  property p_level3;
    @(posedge core_clk) disable iff (srst) irqLevel == 2'h3 |-> !irqRequest;
  endproperty
  a_level3: assert property (p_level3) else $error("level 3 request");
  property p_enable;
    @(posedge core_clk) disable iff (srst) !icr_reg[ICR_EN] |-> !irqRequest;
  endproperty
  a_enable: assert property (p_enable) else $error("disabled request");
  property p_accept;
    @(posedge core_clk) disable iff (srst) irqAccept && !swEdge |=> !icr_reg[ICR_FLAG];
  endproperty
  a_accept: assert property (p_accept) else $error("flag not cleared");
  property p_mask;
    @(posedge core_clk) disable iff (srst)
      irqRequest |-> psw_reg[PSW_MIE] && irqLevel < psw_reg[PSW_IM_HI:PSW_IM_LO];
  endproperty
  a_mask: assert property (p_mask) else $error("masked level passed");
  property p_match;
    @(posedge core_clk) disable iff (srst)
      trig_reg[TRIG_SRC] && freeRunCount == match_reg |=> cfg.headSwitch == $past(storedLevel_reg);
  endproperty
  a_match: assert property (p_match) else $error("match level wrong");
  property p_capture;
    @(posedge core_clk) disable iff (srst)
      captureStrobe |-> (trig_reg[TRIG_EDGE] ? !cfg.headSwitch : cfg.headSwitch);
  endproperty
  a_capture: assert property (p_capture) else $error("capture edge wrong");
  property p_permit;
    @(posedge core_clk) disable iff (srst)
      !memc_reg[MEMC_PERMIT] && !swEdge && !icr_reg[ICR_FLAG] |=> !icr_reg[ICR_FLAG];
  endproperty
  a_permit: assert property (p_permit) else $error("flag set without cause");

  // each edge leaves its own sticky record, whatever the capture edge
  property p_rise_status;
    @(posedge core_clk) disable iff (srst) rise |=> evst_reg[0];
  endproperty
  a_rise_status: assert property (p_rise_status) else $error("rise not recorded");
  property p_fall_status;
    @(posedge core_clk) disable iff (srst) fall |=> evst_reg[1];
  endproperty
  a_fall_status: assert property (p_fall_status) else $error("fall not recorded");
  property p_both_edges;
    @(posedge core_clk) disable iff (srst) fall && !trig_reg[TRIG_EDGE] |=> icr_reg[ICR_FLAG];
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("uncaptured edge lost");

  // plain control writes must leave the request flag alone
  property p_flag_guard;
    @(posedge core_clk) disable iff (srst)
      doWrite && wstrb_reg[0] && awaddr_reg == ADDR_ICR && !memc_reg[MEMC_PERMIT]
        && !irqAccept && !swEdge |=> icr_reg[ICR_FLAG] == $past(icr_reg[ICR_FLAG]);
  endproperty
  a_flag_guard: assert property (p_flag_guard) else $error("flag written without permit");

  // a pending, enabled source within the mask always reaches the core
  property p_admit;
    @(posedge core_clk) disable iff (srst)
      icr_reg[ICR_FLAG] && icr_reg[ICR_EN] && psw_reg[PSW_MIE]
        && irqLevel < psw_reg[PSW_IM_HI:PSW_IM_LO] |-> irqRequest;
  endproperty
  a_admit: assert property (p_admit) else $error("admitted request missing");

  // write answer follows once both halves are held
  sequence s_halves_held;
    awHave_reg && wHave_reg;
  endsequence
  property p_write_answer;
    @(posedge core_clk) disable iff (srst) s_halves_held |=> s_axi_bvalid && !awHave_reg;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
endmodule : head_switch_edge_interrupt

// [bench/hsei_cpu_model.sv]
// cpu interrupt acceptance model for the head-switch interrupt bench
`timescale 1ns/10ps
module hsei_cpu_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // request from the block
  input wire logic irqRequest,
  input wire logic acceptOn,
  input wire logic [3:0] latency,
  // acceptance back to the block
  output logic irqAccept,
  output logic [7:0] acceptCount
);
  logic [3:0] waitCnt;
  // accept presented request
  // a dropped request restarts the wait, as a real core re-arbitrates
  always_ff @(posedge core_clk) begin
    if (srst || irqAccept || !acceptOn || !irqRequest) begin
      waitCnt <= 4'h0;
      irqAccept <= 1'b0;
    end else if (waitCnt == latency) begin
      irqAccept <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acceptCount <= 8'h00;
    end else if (irqAccept) begin
      acceptCount <= acceptCount + 8'h01;
    end
  end
endmodule : hsei_cpu_model

// [bench/testbench.sv]
// self-checking bench for the head-switch edge interrupt block
`timescale 1ns/10ps
module testbench;
  import hsei_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, irqLevel;
  logic [31:0] s_axi_rdata;
  logic [1:0] combinedLevel = 2'h0;
  logic ampPg = 1'b0;
  logic ampFg = 1'b0;
  logic delayPinHigh = 1'b0;
  logic [15:0] freeRunCount = 16'h0000;
  logic delayCharge, headSwitch, captureStrobe, irqRequest, irqAccept, irqOut;
  logic acceptOn = 1'b0;
  logic [3:0] latency = 4'h3;
  logic [7:0] acceptCount;
  int failures = 0;
  int comparisons = 0;
  int captures = 0;

  always #10 core_clk = ~core_clk;

  head_switch_edge_interrupt head_switch_edge_interrupt_inst (.core_clk, .srst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .combinedLevel, .ampPg, .ampFg, .delayPinHigh,
    .freeRunCount, .delayCharge, .headSwitch, .captureStrobe, .irqRequest,
    .irqLevel, .irqAccept, .irqOut);

  hsei_cpu_model hsei_cpu_model_inst (.core_clk, .srst, .irqRequest, .acceptOn,
    .latency, .irqAccept, .acceptCount);

  always @(posedge core_clk) begin
    if (captureStrobe === 1'b1) captures++;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // bus waits are bounded; a stuck slave ends the run
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic [1:0] resp;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      resp = s_axi_bresp;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    #1;
    if (n == 50) begin
      failures++;
      report_and_stop();
    end
    cmp("write response", 32'h0, {30'h0, resp});
  endtask : axw

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    int n;
    logic [31:0] d;
    logic [1:0] resp;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
    if (n == 50) begin
      failures++;
      report_and_stop();
    end
    cmp(what, exp, d);
    cmp("read response", 32'h0, {30'h0, resp});
  endtask : rdChk

  // a wait that runs out of its bound ends the run as a failure
  task automatic limitCheck(input int used, input int bound);
    if (used >= bound) begin
      failures++;
      report_and_stop();
    end
  endtask : limitCheck

  // one-cycle code on the three-level pulse input
  task automatic pulse(input logic [1:0] code);
    @(posedge core_clk);
    combinedLevel <= code;
    @(posedge core_clk);
    combinedLevel <= 2'h0;
  endtask : pulse

  // program the match level, then let the counter hit the match for one cycle
  task automatic setSwitch(input logic lvl);
    axw(ADDR_MATCH, {15'h0000, lvl, 16'h0123});
    @(posedge core_clk);
    freeRunCount <= 16'h0123;
    @(posedge core_clk);
    freeRunCount <= 16'h0000;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : setSwitch

  initial begin
    int lv;
    int m;
    int i;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rdChk(ADDR_ICR, 32'hc0, "control reset");
    rdChk(ADDR_TRIG, 32'h0, "trigger reset");
    rdChk(8'h40, 32'h0, "unmapped");
    cmp("request idle", 32'h0, {31'h0, irqRequest});
    $display("test reset done");
    axw(ADDR_PSW, 32'h00);
    axw(ADDR_MEMC, 32'h04);
    axw(ADDR_ICR, 32'h00);
    axw(ADDR_MEMC, 32'h00);
    axw(ADDR_ICR, 32'h02);
    axw(ADDR_PSW, 32'h70);
    rdChk(ADDR_ICR, 32'h02, "control after init");
    axw(ADDR_EVMASK, 32'h1);
    axw(ADDR_TRIG, 32'h1);
    setSwitch(1'b1);
    cmp("switch match high", 32'h1, {31'h0, headSwitch});
    cmp("request on rise", 32'h1, {31'h0, irqRequest});
    rdChk(ADDR_ICR, 32'h03, "flag on rise");
    cmp("summary on rise", 32'h1, {31'h0, irqOut});
    cmp("capture rise", 32'h1, 32'(captures));
    rdChk(ADDR_STAT, 32'h3, "status on rise");
    $display("test match rise done");
    for (lv = 0; lv < 4; lv++) begin
      for (m = 0; m < 4; m++) begin
        axw(ADDR_ICR, (32'(lv) << 6) | 32'h2);
        axw(ADDR_PSW, 32'h40 | (32'(m) << 4));
        cmp("admit", 32'(lv < m), {31'h0, irqRequest});
        cmp("level", 32'(lv), {30'h0, irqLevel});
      end
    end
    axw(ADDR_ICR, 32'h02);
    axw(ADDR_PSW, 32'h30);
    cmp("master off", 32'h0, {31'h0, irqRequest});
    axw(ADDR_PSW, 32'h70);
    axw(ADDR_ICR, 32'h00);
    cmp("enable off", 32'h0, {31'h0, irqRequest});
    axw(ADDR_ICR, 32'h02);
    cmp("enable on", 32'h1, {31'h0, irqRequest});
    axw(ADDR_EVST, 32'h1);
    cmp("summary cleared", 32'h0, {31'h0, irqOut});
    $display("test levels done");
    acceptOn <= 1'b1;
    setSwitch(1'b0);
    repeat (8) @(posedge core_clk);
    #1;
    cmp("switch match low", 32'h0, {31'h0, headSwitch});
    cmp("accepted", 32'h2, {24'h0, acceptCount});
    cmp("request gone", 32'h0, {31'h0, irqRequest});
    rdChk(ADDR_ICR, 32'h02, "flag after accept");
    rdChk(ADDR_EVST, 32'h2, "fall event");
    cmp("fall masked", 32'h0, {31'h0, irqOut});
    axw(ADDR_EVMASK, 32'h3);
    cmp("fall unmasked", 32'h1, {31'h0, irqOut});
    axw(ADDR_EVST, 32'h2);
    cmp("fall cleared", 32'h0, {31'h0, irqOut});
    cmp("no capture on fall", 32'h1, 32'(captures));
    $display("test accept done");
    latency <= 4'h0;
    axw(ADDR_TRIG, 32'h21);
    setSwitch(1'b1);
    setSwitch(1'b0);
    cmp("capture fall only", 32'h2, 32'(captures));
    cmp("both edges accepted", 32'h4, {24'h0, acceptCount});
    $display("test capture edge done");
    axw(ADDR_TRIG, 32'h0);
    axw(ADDR_ANA, 32'h1);
    @(posedge core_clk);
    ampPg <= 1'b1;
    @(posedge core_clk);
    ampPg <= 1'b0;
    ampFg <= 1'b1;
    @(posedge core_clk);
    ampFg <= 1'b0;
    for (i = 0; i < 40 && delayCharge !== 1'b1; i++) @(posedge core_clk);
    limitCheck(i, 40);
    cmp("charge after fg one", 32'h1, {31'h0, delayCharge});
    cmp("switch before threshold", 32'h0, {31'h0, headSwitch});
    @(posedge core_clk);
    delayPinHigh <= 1'b1;
    for (i = 0; i < 40 && headSwitch !== 1'b1; i++) @(posedge core_clk);
    limitCheck(i, 40);
    cmp("switch rise after pg", 32'h1, {31'h0, headSwitch});
    delayPinHigh <= 1'b0;
    repeat (6) @(posedge core_clk);
    cmp("analog edge accepted", 32'h5, {24'h0, acceptCount});
    cmp("capture analog rise", 32'h3, 32'(captures));
    $display("test analog delay done");
    axw(ADDR_ANA, 32'h0);
    axw(ADDR_OPT, 32'h1);
    axw(ADDR_DTIME, 32'h5);
    axw(ADDR_DDC, 32'hc2);
    pulse(2'h2);
    pulse(2'h1);
    pulse(2'h1);
    repeat (5) @(posedge core_clk);
    cmp("switch held during count", 32'h1, {31'h0, headSwitch});
    for (i = 0; i < 40 && headSwitch !== 1'b0; i++) @(posedge core_clk);
    limitCheck(i, 40);
    cmp("switch fall after pg", 32'h0, {31'h0, headSwitch});
    repeat (4) @(posedge core_clk);
    #1;
    cmp("digital edge accepted", 32'h6, {24'h0, acceptCount});
    cmp("no capture on digital fall", 32'h3, 32'(captures));
    $display("test digital delay done");
    report_and_stop();
  end
endmodule : testbench
